// *** logic/fsw_sweep.sv ***
// Frequency sweep sequencer with AHB-Lite register slave and list mode.
// Assumes one slave on the bus, single word transfers, trigger pin synchronous to hclk.
// Function
// [RULE_01] Linear type steps frequency by one fixed increment.
// [RULE_02] Log type step grows with frequency: current value shifted right.
// [RULE_03] Phase stays continuous; accumulator is never reloaded.
// [RULE_04] Up when start below stop, down when above.
// [RULE_05] Sync switches at mark crossing; mark lies between start and stop.
// [RULE_06] Sweep lasts programmed time with constant step interval.
// [RULE_07] Stop frequency is held for the hold duration.
// [RULE_08] Frequency returns to start over the return duration.
// [RULE_09] Interval duration separates consecutive sweep cycles.
// [RULE_10] Internal source repeats sweep cycles continuously.
// [RULE_11] Manual source runs one cycle per manual request.
// [RULE_12] External source runs one cycle per active trigger edge.
// [RULE_13] External trigger period exceeds sweep, hold, return and interval sum.
// [RULE_14] Rising edge selects 0 to 1, falling selects 1 to 0.
// [RULE_15] Trigger output mode off drives nothing on the pin.
// [RULE_16] Rising mode: high at start, low at mark; falling inverted.
// [RULE_17] Internal sync rises at start frequency, falls at mark.
// [RULE_18] Manual or external sync follows the trigger events.
// [RULE_19] List type loops stored frequencies paced by sample rate.
// [RULE_20] Each list point stands one sample period.
// [RULE_21] List repeats at sample rate divided by list length.
// [RULE_22] New step frequency changes only the increment, at a tick.
// [RULE_23] One down-counter times sweep, hold, return and interval.
`timescale 1ns/1ns
`include "fsw_cfg.svh"
module fsw_sweep import fsw_pkg::*; #(
	parameter int FW = 32,
	parameter int AW = 9
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	// Trigger in/out pin
	input  wire logic          trig_in,
	output logic               trig_out,
	output logic               trig_oe_n,
	// Synthesis stage
	output logic               sync_out,
	output logic      [FW-1:0] phase_inc,
	output logic      [FW-1:0] phase
);
	logic [31:0] ctrl, f_start, f_stop, f_mark, lstep, sweep_t, step_t;
	logic [31:0] hold_t, ret_t, gap_t, lrate, llen;
	logic [4:0]  logk;
	logic [AW-1:0] laddr;
	logic        dp_wr, man_req;
	logic [7:0]  dp_addr;
	logic [31:0] next_ctrl, next_start, next_stop, next_mark, next_lstep, next_sweep, next_stept;
	logic [31:0] next_hold, next_ret, next_gap, next_lrate, next_llen, next_hrdata;
	logic [4:0]  next_logk;
	logic [AW-1:0] next_laddr;
	logic        next_dp_wr, next_man;
	logic [7:0]  next_dp_addr;
	logic        ap_sel, mem_we;
	logic [31:0] rdata;

	fsw_state_e  st, next_st;
	logic [31:0] cnt, tick_cnt, next_cnt, next_tick_cnt;
	logic [FW-1:0] next_inc;
	logic [AW-1:0] idx, next_idx;
	logic        up, act, wrap, ext_q;
	logic        next_up, next_act, next_wrap, next_sync, next_tout, next_toe_n;
	logic        en, tick, ext_edge, start_ev, crossed;
	fsw_type_e   typ;
	fsw_src_e    src;
	fsw_tout_e   tmode;

	assign ap_sel = hsel && htrans[1] && hready;
	assign mem_we = dp_wr && (dp_addr == `FSW_A_LDATA);

	// Register slave: zero wait states, so read data is latched in the address phase
	always_comb begin
		next_ctrl = ctrl;
		next_start = f_start;
		next_stop = f_stop;
		next_mark = f_mark;
		next_lstep = lstep;
		next_logk = logk;
		next_sweep = sweep_t;
		next_stept = step_t;
		next_hold = hold_t;
		next_ret = ret_t;
		next_gap = gap_t;
		next_lrate = lrate;
		next_llen = llen;
		next_laddr = laddr;
		next_man = 1'b0;
		next_dp_wr = ap_sel && hwrite;
		next_dp_addr = ap_sel ? haddr[7:0] : dp_addr;
		next_hrdata = hrdata;
		if (dp_wr) begin
			case (dp_addr)
				`FSW_A_CTRL:  next_ctrl = hwdata;
				`FSW_A_START: next_start = hwdata;
				`FSW_A_STOP:  next_stop = hwdata;
				`FSW_A_MARK:  next_mark = hwdata;
				`FSW_A_LSTEP: next_lstep = hwdata;
				`FSW_A_LOGK:  next_logk = hwdata[4:0];
				`FSW_A_SWEEP: next_sweep = hwdata;
				`FSW_A_STEPT: next_stept = hwdata;
				`FSW_A_HOLD:  next_hold = hwdata;
				`FSW_A_RET:   next_ret = hwdata;
				`FSW_A_GAP:   next_gap = hwdata;
				`FSW_A_LRATE: next_lrate = hwdata;
				`FSW_A_LLEN:  next_llen = hwdata;
				`FSW_A_LADDR: next_laddr = hwdata[AW-1:0];
				`FSW_A_LDATA: next_laddr = laddr + 1'b1;
				`FSW_A_MTRIG: next_man = hwdata[0]; // [RULE_11]
				default:      next_man = 1'b0;
			endcase
		end
		if (ap_sel && !hwrite) begin
			case (haddr[7:0])
				`FSW_A_CTRL:   next_hrdata = ctrl;
				`FSW_A_START:  next_hrdata = f_start;
				`FSW_A_STOP:   next_hrdata = f_stop;
				`FSW_A_MARK:   next_hrdata = f_mark;
				`FSW_A_LSTEP:  next_hrdata = lstep;
				`FSW_A_LOGK:   next_hrdata = {27'h0, logk};
				`FSW_A_SWEEP:  next_hrdata = sweep_t;
				`FSW_A_STEPT:  next_hrdata = step_t;
				`FSW_A_HOLD:   next_hrdata = hold_t;
				`FSW_A_RET:    next_hrdata = ret_t;
				`FSW_A_GAP:    next_hrdata = gap_t;
				`FSW_A_LRATE:  next_hrdata = lrate;
				`FSW_A_LLEN:   next_hrdata = llen;
				`FSW_A_LADDR:  next_hrdata = 32'(laddr);
				`FSW_A_STATUS: next_hrdata = {25'h0, sync_out, act, up, 1'b0, st};
				`FSW_A_FREQ:   next_hrdata = 32'(phase_inc);
				default:       next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= `FSW_RST_CTRL;
			f_start <= '0;
			f_stop <= '0;
			f_mark <= '0;
			lstep <= '0;
			logk <= '0;
			sweep_t <= `FSW_RST_TIME;
			step_t <= `FSW_RST_TIME;
			hold_t <= `FSW_RST_TIME;
			ret_t <= `FSW_RST_TIME;
			gap_t <= `FSW_RST_TIME;
			lrate <= `FSW_RST_TIME;
			llen <= `FSW_RST_LLEN;
			laddr <= '0;
			man_req <= 1'b0;
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			f_start <= next_start;
			f_stop <= next_stop;
			f_mark <= next_mark;
			lstep <= next_lstep;
			logk <= next_logk;
			sweep_t <= next_sweep;
			step_t <= next_stept;
			hold_t <= next_hold;
			ret_t <= next_ret;
			gap_t <= next_gap;
			lrate <= next_lrate;
			llen <= next_llen;
			laddr <= next_laddr;
			man_req <= next_man;
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	fsw_list_mem #(.W(FW), .AW(AW)) i_fsw_list_mem (
		.hclk    (hclk),
		.hresetn (hresetn),
		.we      (mem_we),
		.waddr   (laddr),
		.wdata   (hwdata[FW-1:0]),
		.raddr   (idx),
		.rdata   (rdata[FW-1:0])
	);
	if (FW < 32) begin : g_pad
		assign rdata[31:FW] = '0;
	end

	fsw_phase_acc #(.FW(FW)) i_fsw_phase_acc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.inc     (phase_inc),
		.phase   (phase)
	);

	// One step toward a target, clamped so it never overshoots
	function automatic logic [FW-1:0] step_to(input logic [FW-1:0] cur, input logic [FW-1:0] tgt,
		input logic dir_up, input logic [FW-1:0] d);
		logic [FW:0] s;
		s = dir_up ? ({1'b0, cur} + {1'b0, d}) : ({1'b0, cur} - {1'b0, d});
		if (dir_up) begin
			step_to = (s >= {1'b0, tgt}) ? tgt : s[FW-1:0];
		end else begin
			step_to = (s[FW] || s[FW-1:0] <= tgt) ? tgt : s[FW-1:0];
		end
	endfunction

	logic [FW-1:0] delta;
	logic [31:0]   tick_load;
	always_comb begin
		en = ctrl[`FSW_C_EN];
		typ = fsw_type_e'(ctrl[`FSW_C_TYPE]);
		src = fsw_src_e'(ctrl[`FSW_C_SRC]);
		tmode = fsw_tout_e'(ctrl[`FSW_C_TOUT]);
		ext_edge = ctrl[`FSW_C_FALL] ? (ext_q && !trig_in) : (!ext_q && trig_in); // [RULE_14]
		start_ev = en && ((src == FSW_INT) // [RULE_10]
			|| (src == FSW_MAN && man_req) // [RULE_11]
			|| (src == FSW_EXT && ext_edge)); // [RULE_12]
		tick = (tick_cnt == 32'h0000_0000);
		// Log step is a fixed fraction of the current value, never zero
		delta = (typ == FSW_LOG) ? (phase_inc >> logk) : lstep[FW-1:0]; // [RULE_01] [RULE_02]
		if (delta == '0) begin
			delta = FW'(1);
		end
		// Reload holds the period less one, so the first step stands as long as every later one
		tick_load = (st != FSW_LIST) ? step_t
			: (lrate < `FSW_MIN_LRATE) ? `FSW_MIN_LRATE - 32'h0000_0001 : lrate - 32'h0000_0001;
		crossed = up ? (phase_inc >= f_mark[FW-1:0]) : (phase_inc <= f_mark[FW-1:0]);
	end

	// Sequencer
	always_comb begin
		next_st = st;
		next_cnt = (cnt != 32'h0000_0000) ? cnt - 1'b1 : cnt; // [RULE_23]
		next_tick_cnt = tick ? tick_load : tick_cnt - 1'b1; // [RULE_06]
		next_inc = phase_inc;
		next_idx = idx;
		next_up = up;
		next_act = act;
		next_wrap = wrap;
		next_sync = sync_out;
		case (st)
			FSW_IDLE: begin
				next_tick_cnt = tick_cnt;
				if (start_ev && typ == FSW_LST) begin
					next_st = FSW_LIST;
					next_idx = '0;
					next_wrap = 1'b0;
					next_tick_cnt = 32'h0000_0001;
				end else if (start_ev) begin
					next_st = FSW_SWEEP;
					next_inc = f_start[FW-1:0];
					next_up = f_start < f_stop; // [RULE_04]
					next_cnt = sweep_t; // [RULE_23]
					next_tick_cnt = step_t;
					next_sync = 1'b1; // [RULE_17] [RULE_18]
					next_act = 1'b1; // [RULE_16]
				end
			end
			FSW_SWEEP: begin
				if (crossed) begin
					next_sync = 1'b0; // [RULE_05]
					next_act = 1'b0; // [RULE_16]
				end
				if (cnt == 32'h0000_0000) begin
					next_st = FSW_HOLD;
					next_inc = f_stop[FW-1:0]; // [RULE_06]
					next_cnt = hold_t; // [RULE_07]
				end else if (tick) begin
					next_inc = step_to(phase_inc, f_stop[FW-1:0], up, delta); // [RULE_22]
				end
			end
			FSW_HOLD: begin
				next_tick_cnt = step_t;
				if (cnt == 32'h0000_0000) begin
					next_st = FSW_RET;
					next_cnt = ret_t; // [RULE_08]
				end
			end
			FSW_RET: begin
				if (cnt == 32'h0000_0000) begin
					next_st = FSW_GAP;
					next_inc = f_start[FW-1:0]; // [RULE_08]
					next_cnt = gap_t; // [RULE_09]
				end else if (tick) begin
					next_inc = step_to(phase_inc, f_start[FW-1:0], !up, delta);
				end
			end
			FSW_GAP: begin
				if (cnt == 32'h0000_0000) begin
					next_st = FSW_IDLE; // [RULE_09]
				end
			end
			FSW_LIST: begin
				if (tick && wrap && src != FSW_INT) begin
					next_st = FSW_IDLE;
					next_wrap = 1'b0;
				end else if (tick) begin
					next_inc = rdata[FW-1:0]; // [RULE_19] [RULE_20]
					next_sync = 32'(idx) < (llen >> 1);
					next_act = (32'(idx) + 1) < llen;
					next_wrap = (32'(idx) + 1) >= llen; // [RULE_21]
					next_idx = next_wrap ? '0 : idx + 1'b1;
				end
			end
			default: next_st = FSW_IDLE;
		endcase
		if (!en) begin
			next_st = FSW_IDLE;
			next_sync = 1'b0;
			next_act = 1'b0;
		end
		next_toe_n = !(tmode != FSW_TOFF && src != FSW_EXT); // [RULE_15]
		next_tout = (tmode == FSW_TFALL) ? !next_act : next_act; // [RULE_16]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= FSW_IDLE;
			cnt <= '0;
			tick_cnt <= '0;
			phase_inc <= '0;
			idx <= '0;
			up <= 1'b0;
			act <= 1'b0;
			wrap <= 1'b0;
			sync_out <= 1'b0;
			trig_out <= 1'b0;
			trig_oe_n <= 1'b1;
			ext_q <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			tick_cnt <= next_tick_cnt;
			phase_inc <= next_inc;
			idx <= next_idx;
			up <= next_up;
			act <= next_act;
			wrap <= next_wrap;
			sync_out <= next_sync;
			trig_out <= next_tout;
			trig_oe_n <= next_toe_n;
			ext_q <= trig_in;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_sweep_done;
		st == FSW_SWEEP && cnt == 32'h0000_0000 && en;
	endsequence
	sequence s_hold_entry;
		st == FSW_HOLD && phase_inc == f_stop[FW-1:0] && cnt == $past(hold_t);
	endsequence

	a_hold_entry: assert property (s_sweep_done |=> s_hold_entry) // [RULE_07]
		else $error("hold not entered at stop frequency");
	a_hold_stays: assert property (st == FSW_HOLD && en |=> $stable(phase_inc)) // [RULE_07]
		else $error("frequency moved during hold");
	a_ret_end: assert property (st == FSW_RET && cnt == 32'h0000_0000 && en // [RULE_08]
		|=> st == FSW_GAP && phase_inc == f_start[FW-1:0])
		else $error("return did not end at start frequency");
	a_gap_idle: assert property (st == FSW_GAP && cnt == 32'h0000_0000 && en |=> st == FSW_IDLE) // [RULE_09]
		else $error("interval did not end");
	a_sweep_start: assert property (st == FSW_IDLE && start_ev && typ != FSW_LST // [RULE_17]
		|=> st == FSW_SWEEP && sync_out && phase_inc == f_start[FW-1:0])
		else $error("sweep start wrong");
	a_up_mono: assert property (st == FSW_SWEEP && up && cnt != 32'h0000_0000 && en // [RULE_04]
		|=> phase_inc >= $past(phase_inc))
		else $error("upward sweep went down");
	a_mark_sync: assert property (st == FSW_SWEEP && crossed && en |=> !sync_out) // [RULE_05]
		else $error("sync missed mark point");
	a_trig_off: assert property (tmode == FSW_TOFF |=> trig_oe_n) // [RULE_15]
		else $error("trigger pin driven while off");
	a_list_hold: assert property (st == FSW_LIST && !tick && en |=> $stable(phase_inc)) // [RULE_20]
		else $error("list point changed between ticks");
	a_idle_start: assert property (st == FSW_IDLE && en && src == FSW_INT && typ != FSW_LST // [RULE_10]
		|=> st == FSW_SWEEP)
		else $error("internal source did not repeat");
endmodule

// *** logic/fsw_cfg.svh ***
// Register map, field positions, reset values and timing for the sweep block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one register per word.
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH
`define FSW_A_CTRL      8'h00
`define FSW_A_START     8'h04
`define FSW_A_STOP      8'h08
`define FSW_A_MARK      8'h0C
`define FSW_A_LSTEP     8'h10
`define FSW_A_LOGK      8'h14
`define FSW_A_SWEEP     8'h18
`define FSW_A_STEPT     8'h1C
`define FSW_A_HOLD      8'h20
`define FSW_A_RET       8'h24
`define FSW_A_GAP       8'h28
`define FSW_A_LRATE     8'h2C
`define FSW_A_LLEN      8'h30
`define FSW_A_LADDR     8'h34
`define FSW_A_LDATA     8'h38
`define FSW_A_MTRIG     8'h3C
`define FSW_A_STATUS    8'h40
`define FSW_A_FREQ      8'h44
`define FSW_C_EN        0
`define FSW_C_TYPE      2:1
`define FSW_C_SRC       4:3
`define FSW_C_FALL      5
`define FSW_C_TOUT      7:6
`define FSW_RST_CTRL    32'h0000_0000
`define FSW_RST_TIME    32'h0000_0010
`define FSW_RST_LLEN    32'h0000_0004
`define FSW_MIN_LRATE   32'h0000_0002
`define FSW_CLK_NS      8
`endif

// *** logic/fsw_pkg.sv ***
// Types used by the sweep sequencer alone.
// Assumes fsw_cfg.svh supplies the numeric constants.
package fsw_pkg;
	typedef enum logic [2:0] {FSW_IDLE, FSW_SWEEP, FSW_HOLD, FSW_RET, FSW_GAP, FSW_LIST} fsw_state_e;
	typedef enum logic [1:0] {FSW_LIN, FSW_LOG, FSW_LST} fsw_type_e;
	typedef enum logic [1:0] {FSW_INT, FSW_MAN, FSW_EXT} fsw_src_e;
	typedef enum logic [1:0] {FSW_TOFF, FSW_TRISE, FSW_TFALL} fsw_tout_e;
endpackage

// *** logic/fsw_list_mem.sv ***
// Frequency list storage: one write port, one registered read port.
// Assumes the writer and reader share hclk.
`timescale 1ns/1ns
module fsw_list_mem #(
	parameter int W  = 32,
	parameter int AW = 9
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read side
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// *** logic/fsw_phase_acc.sv ***
// Phase accumulator of the synthesis stage.
// Assumes the increment may change on any edge; the phase itself is never reloaded.
`timescale 1ns/1ns
module fsw_phase_acc #(
	parameter int FW = 32
) (
	// Clock and reset
	input  wire logic          hclk,
	input  wire logic          hresetn,
	// Increment in, phase out
	input  wire logic [FW-1:0] inc,
	output logic      [FW-1:0] phase
);
	logic [FW-1:0] next_phase;

	always_comb begin
		next_phase = phase + inc; // [RULE_03]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= '0;
		end else begin
			phase <= next_phase;
		end
	end

	a_phase_cont: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_03]
		##1 phase == FW'($past(phase) + $past(inc)))
		else $error("phase jumped instead of accumulating");
endmodule

// *** verif/fsw_trig_far.sv ***
// Far-side model of the trigger pin: an external trigger source sharing the pin.
// Assumes the bench asks for pin levels synchronous to hclk.
`timescale 1ns/1ns
module fsw_trig_far #(
	parameter int MIN_GAP = 48
) (
	// Clock
	input  wire logic hclk,
	// Requested source level
	input  wire logic set_lvl,
	// Device side of the pin
	input  wire logic trig_out,
	input  wire logic trig_oe_n,
	output logic      pin
);
	logic lvl;
	int   gap;
	initial begin
		lvl = 1'b0;
		gap = MIN_GAP;
	end
	// An edge waits until the last one is older than a full sweep cycle
	always @(posedge hclk) begin
		if (set_lvl !== lvl && gap >= MIN_GAP) begin
			lvl <= set_lvl;
			gap <= 0;
		end else begin
			gap <= gap + 1;
		end
	end
	// Device wins the wire while its enable is low
	assign pin = trig_oe_n ? lvl : trig_out;
endmodule

// *** verif/fsw_sweep_bench.sv ***
// Self-checking bench for the sweep sequencer: AHB-Lite master, trigger source, reference model.
// Assumes the design files and fsw_cfg.svh are compiled first.
`timescale 1ns/1ns
`include "fsw_cfg.svh"
module fsw_sweep_bench;
	logic        hclk, hresetn, hsel, hwrite, sync_out, trig_out, trig_oe_n, hreadyout, hresp, pin, set_lvl;
	logic [31:0] haddr, hwdata, hrdata, phase_inc, phase, p_ph, p_inc, stp, m_start, m_tgt, m_mark, rd;
	logic [1:0]  htrans, m_tout;
	logic        p_sync, m_on, m_up, m_log, m_lst;
	int          fails, cmp_count, cyc, lt, lt_r, per, rises, lidx, m_k, seed, n, ls;
	logic [31:0] lv[$];
	logic [7:0]  ra[5];
	logic [31:0] re[5];

	fsw_sweep i_fsw_sweep (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .trig_in(pin), .trig_out(trig_out), .trig_oe_n(trig_oe_n),
		.sync_out(sync_out), .phase_inc(phase_inc), .phase(phase));
	fsw_trig_far i_fsw_trig_far (.hclk(hclk), .set_lvl(set_lvl), .trig_out(trig_out),
		.trig_oe_n(trig_oe_n), .pin(pin));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task stop_test();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			fails++;
			stop_test();
		end
	endtask

	// One single AHB-Lite word transfer; read data taken at the end of the data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h0, a};
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		chk("hresp", 32'h0, hresp);
	endtask

	task wait_cyc(input int c);
		repeat (c) @(posedge hclk);
	endtask

	task run_sweep(input logic [31:0] st, input logic [31:0] sp, input logic [31:0] mk, input int k,
		input logic [7:0] c);
		m_on <= 1'b0;
		bus(1, `FSW_A_CTRL, 32'h0);
		bus(1, `FSW_A_START, st);
		bus(1, `FSW_A_STOP, sp);
		bus(1, `FSW_A_MARK, mk);
		bus(1, `FSW_A_LSTEP, 32'hA);
		bus(1, `FSW_A_LOGK, k);
		bus(1, `FSW_A_SWEEP, 32'h13);
		bus(1, `FSW_A_STEPT, 32'h1);
		bus(1, `FSW_A_HOLD, 32'h5);
		bus(1, `FSW_A_RET, 32'h7);
		bus(1, `FSW_A_GAP, 32'h4);
		{m_start, m_tgt, m_mark, m_k, m_up, m_log, m_tout} = {st, sp, mk, k, st < sp, c[1], c[7:6]};
		rises = 0;
		per = 0;
		bus(1, `FSW_A_CTRL, {24'h0, c});
		wait_cyc(2);
		m_on <= 1'b1;
		for (n = 0; n < 400 && rises < 3; n++) wait_cyc(1);
		chk("sweep rises", 3, rises);
		// Start, sweep, hold, return and gap each last their count plus one
		chk("sync period", 19 + 5 + 7 + 4 + 5, per);
		$display("sweep test %h done", c);
	endtask

	// Reference model, compared at every clock
	always @(posedge hclk) begin
		if (!hresetn) begin
			{p_ph, p_inc, p_sync} = '0;
		end else begin
			cyc++;
			chk("phase", p_ph + p_inc, phase);
			if (m_on) begin
				stp = m_log ? ((p_inc >> m_k) == 0 ? 32'h1 : p_inc >> m_k) : 32'hA;
				// Step time is STEPT+1 cycles, counted from the sweep start or the last step
				if (m_up && phase_inc > p_inc && p_inc >= m_start && phase_inc !== m_tgt) begin
					chk("up step", p_inc + stp, phase_inc);
					chk("step time", 2, cyc - ls);
					ls = cyc;
				end
				if (!m_up && phase_inc < p_inc && p_inc <= m_start && phase_inc !== m_tgt) begin
					chk("down step", p_inc - stp, phase_inc);
					chk("step time", 2, cyc - ls);
					ls = cyc;
				end
				if (p_sync && !sync_out)
					chk("mark", 1, m_up ? phase_inc >= m_mark : phase_inc <= m_mark);
				if (m_tout == 2'd0) chk("trig oe_n", 1, trig_oe_n);
				else chk("trig", m_tout == 2'd1 ? sync_out : !sync_out, trig_out);
			end
			if (m_lst && phase_inc !== p_inc) begin
				if (lidx > 0) chk("list period", 5, cyc - lt);
				chk("list value", lv[lidx % lv.size()], phase_inc);
				lidx++;
				lt = cyc;
			end
			if (sync_out && !p_sync) begin
				if (rises > 0) per = cyc - lt_r;
				lt_r = cyc;
				ls = cyc;
				rises++;
			end
			p_ph   = phase;
			p_inc  = phase_inc;
			p_sync = sync_out;
		end
	end

	initial begin
		#640000;
		fails++;
		stop_test();
	end

	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, set_lvl, m_on, m_lst} = '0;
		{fails, cmp_count, cyc, rises, lidx, per, lt, lt_r, ls} = '0;
		seed = 32'hA142;
		hresetn = 1'b0;
		wait_cyc(5);
		hresetn <= 1'b1;
		// Reset values, unmapped address reads zero after a write
		ra = '{`FSW_A_CTRL, `FSW_A_SWEEP, `FSW_A_LLEN, `FSW_A_LADDR, 8'h80};
		re = '{`FSW_RST_CTRL, `FSW_RST_TIME, `FSW_RST_LLEN, 32'h0, 32'h0};
		bus(1, 8'h80, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) begin
			bus(0, ra[i], 32'h0);
			chk("reset value", re[i], rd);
		end
		$display("register test done");
		run_sweep(32'd100, 32'd200, 32'd150, 0, 8'h41);
		run_sweep(32'd100, 32'd400, 32'd250, 2, 8'h83);
		run_sweep(32'd200, 32'd100, 32'd150, 0, 8'h01);
		// Manual: no start on its own, then one cycle per request; trigger out now rising mode
		m_tout = 2'd1;
		bus(1, `FSW_A_CTRL, 32'h49);
		rises = 0;
		wait_cyc(100);
		for (int i = 1; i <= 2; i++) begin
			bus(1, `FSW_A_MTRIG, 32'h1);
			wait_cyc(100);
			chk("manual cycles", i, rises);
		end
		$display("manual test done");
		// External, rising then falling edge select: the wrong edge must not start
		m_on <= 1'b0;
		for (int f = 0; f < 2; f++) begin
			bus(1, `FSW_A_CTRL, 32'h11 | (f << 5));
			wait_cyc(100);
			rises = 0;
			set_lvl <= 1'b1;
			wait_cyc(100);
			set_lvl <= 1'b0;
			wait_cyc(100);
			chk("external cycles", 1, rises);
		end
		$display("external test done");
		bus(1, `FSW_A_CTRL, 32'h0);
		bus(1, `FSW_A_LRATE, 32'h5);
		bus(1, `FSW_A_LADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			lv.push_back(32'h1000 * (i + 1) + ($random(seed) & 32'hFF));
			bus(1, `FSW_A_LDATA, lv[i]);
		end
		m_lst = 1'b1;
		bus(1, `FSW_A_CTRL, 32'h05);
		for (n = 0; n < 300 && lidx < 12; n++) wait_cyc(1);
		chk("list points", 12, lidx);
		$display("list test done");
		stop_test();
	end
endmodule
